// *** shared/rmcg_pkg.sv ***
// Constants shared by the run-mode clock gating block and its unit gate stages.
package rmcg_pkg;

	// Byte offsets of the registers, compared against haddr[11:0].
	localparam logic [11:0] RUN_GATE_OFS   = 12'h100;
	localparam logic [11:0] SLEEP_GATE_OFS = 12'h110;
	localparam logic [11:0] DEEP_GATE_OFS  = 12'h120;
	localparam logic [11:0] RUN_CFG_OFS    = 12'h060;
	localparam logic [11:0] IRQ_STAT_OFS   = 12'h140;
	localparam logic [11:0] IRQ_MASK_OFS   = 12'h144;

	// Bit positions inside a gating register.
	localparam int PWM_BIT  = 20;
	localparam int CONV_BIT = 16;
	localparam int WDT_BIT  = 3;
	localparam int RATE_LSB = 8;

	// Bit position of the auto gating select in the run clock configuration.
	localparam int AUTO_GATE_BIT = 0;

	// Reset value of each gating register; bit 6 is a reserved bit that reads one.
	localparam logic [31:0] GATE_RESET = 32'h0000_0040;

	// Reset values of the stored fields.
	localparam logic [2:0] UNITS_RESET = 3'h0;
	localparam logic [1:0] RATE_RESET  = 2'h0;
	localparam logic [2:0] STAT_RESET  = 3'h0;
	localparam logic [2:0] MASK_RESET  = 3'h0;

	// Unit indices, also the bit positions in the interrupt status and mask.
	localparam int NUM_UNITS = 3;
	localparam int UNIT_PWM  = 0;
	localparam int UNIT_CONV = 1;
	localparam int UNIT_WDT  = 2;

	// Number of gating sets: run, sleep and deep sleep.
	localparam int NUM_SETS = 3;

	// Converter sample rate encodings.
	localparam logic [1:0] RATE_125K = 2'h0;
	localparam logic [1:0] RATE_250K = 2'h1;
	localparam logic [1:0] RATE_500K = 2'h2;

	// AHB-Lite codes used by the slave.
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic       HRESP_OKAY = 1'b0;

	// Power state that picks the gating set.
	typedef enum logic [1:0] {
		PM_RUN,
		PM_SLEEP,
		PM_DEEP
	} rmcg_pmode_e;

endpackage

// *** hdl/rmcg_gate_sel.sv ***
`timescale 1ns/100ps
// One unit's clock enable stage: picks the gating set, registers the enable
// and flags accesses that reach the unit while its clock is off.
module rmcg_gate_sel (
	// Clock and reset.
	input  wire logic                  mclk,
	input  wire logic                  reset,
	// Enable bits of this unit in the three gating sets.
	input  wire logic                  run_en,
	input  wire logic                  sleep_en,
	input  wire logic                  deep_en,
	// Set selection.
	input  wire logic                  auto_gate,
	input  wire rmcg_pkg::rmcg_pmode_e pmode,
	// Unit access and results.
	input  wire logic                  unit_access,
	output logic                       unit_clk_en,
	output logic                       unit_fault
);

	// All state of the stage.
	typedef struct packed {
		logic en;     // Enable currently applied to the unit clock.
		logic fault;  // One-cycle fault pulse.
	} rmcg_gate_s;

	rmcg_gate_s st_q;  // Registered state.
	rmcg_gate_s st_d;  // Next state.
	logic       sel;   // Enable of the set in force.

	// The set in force follows the power state only while auto gating is on.
	always_comb begin
		st_d = st_q;
		sel = run_en;
		if (auto_gate) begin
			case (pmode)
				rmcg_pkg::PM_SLEEP: begin
					sel = sleep_en;
				end
				rmcg_pkg::PM_DEEP: begin
					sel = deep_en;
				end
				default: begin
					sel = run_en;
				end
			endcase
		end
		// The enable moves only on a clock edge, so the unit's gate cell never
		// sees a half-cycle change.
		st_d.en = sel;
		// A unit without clock cannot answer, so the access becomes a fault.
		st_d.fault = unit_access && !st_q.en;
	end

	// State register; reset leaves the unit unclocked.
	always_ff @(posedge mclk) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from the state register.
	assign unit_clk_en = st_q.en;
	assign unit_fault  = st_q.fault;

endmodule

// *** hdl/rmcg_top.sv ***
`timescale 1ns/100ps
// Summary of operation
// - Each gate bit enables one unit clock.
// - Access to unclocked unit gives bus fault; here the bus answers OKAY and the unit_fault pulse sets a status bit.
// - Reset clears all gate bits.
// - Gate register resets to 0x00000040.
// - Bit 20 gates the PWM clock.
// - Bit 16 gates the converter clock.
// - Bit 3 gates the watchdog clock.
// - Bits 9:8 select converter sample rate.
// - Reserved bits are read-only fixed values.
// - This set applies in normal running, and in every state without auto gating.
// - Sleep sets apply only with auto gating.
module rmcg_top (
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        reset,
	// AHB-Lite slave port.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Power state from the processor.
	input  wire logic        sleep_mode,
	input  wire logic        deep_sleep_mode,
	// Unit clock enables and access faults, index 0 PWM, 1 converter, 2 watchdog.
	input  wire logic [2:0]  unit_access,
	output logic [2:0]       unit_clk_en,
	output logic [2:0]       unit_fault,
	// Converter sample rate in force.
	output logic [1:0]       converter_sample_rate,
	// Interrupt.
	output logic             irq
);

	// All state of the block.
	typedef struct packed {
		logic [2:0][2:0] gates;     // Unit enables per set: 0 run, 1 sleep, 2 deep.
		logic [2:0][1:0] rate;      // Sample rate field per set.
		logic            auto_gate; // Auto gating select.
		logic [2:0]      stat;      // Sticky fault status per unit.
		logic [2:0]      mask;      // Interrupt mask per unit.
		logic            dp_valid;  // A data phase is in progress.
		logic            dp_write;  // The data phase is a write.
		logic [11:0]     dp_addr;   // Offset of the data phase.
		logic [31:0]     rdata;     // Read data for the data phase.
		logic            readyout;  // Slave ready.
		logic            resp;      // Slave response.
		logic            irq;       // Interrupt output.
		logic [1:0]      rate_out;  // Sample rate in force.
	} rmcg_top_s;

	rmcg_top_s                s_q;      // Registered state.
	rmcg_top_s                s_d;      // Next state.
	rmcg_pkg::rmcg_pmode_e    pmode;    // Current power state.
	logic [2:0]               fault_ev; // Fault pulses from the unit stages.
	logic                     addr_ok;  // Address phase taken this cycle.
	logic [1:0]               set_idx;  // Gating set in force.

	// Builds a gating register word from its stored fields.
	function automatic logic [31:0] gate_word(logic [2:0] en, logic [1:0] rt);
		logic [31:0] w;
		// Reserved bits always show their fixed values; bit 6 reads one.
		w = rmcg_pkg::GATE_RESET;
		w[rmcg_pkg::PWM_BIT]  = en[rmcg_pkg::UNIT_PWM];
		w[rmcg_pkg::CONV_BIT] = en[rmcg_pkg::UNIT_CONV];
		w[rmcg_pkg::WDT_BIT]  = en[rmcg_pkg::UNIT_WDT];
		w[rmcg_pkg::RATE_LSB +: 2] = rt;
		return w;
	endfunction

	// Deep sleep outranks sleep when both are signalled.
	always_comb begin
		if (deep_sleep_mode) begin
			pmode = rmcg_pkg::PM_DEEP;
		end else if (sleep_mode) begin
			pmode = rmcg_pkg::PM_SLEEP;
		end else begin
			pmode = rmcg_pkg::PM_RUN;
		end
	end

	// Main next-state logic: bus slave, register writes, status and interrupt.
	always_comb begin
		s_d = s_q;
		addr_ok = hsel && htrans[1] && hready;
		// Zero-wait slave with an OKAY answer on every transfer.
		s_d.readyout = 1'b1;
		s_d.resp = rmcg_pkg::HRESP_OKAY;
		// Register writes land at the end of their data phase.
		if (s_q.dp_valid && s_q.dp_write) begin
			case (s_q.dp_addr)
				rmcg_pkg::RUN_GATE_OFS,
				rmcg_pkg::SLEEP_GATE_OFS,
				rmcg_pkg::DEEP_GATE_OFS: begin
					// Only the writable bits are stored; reserved bits ignore writes.
					for (int k = 0; k < rmcg_pkg::NUM_SETS; k++) begin
						if (s_q.dp_addr == (rmcg_pkg::RUN_GATE_OFS + 12'(k * 16))) begin
							s_d.gates[k][rmcg_pkg::UNIT_PWM] = hwdata[rmcg_pkg::PWM_BIT];
							s_d.gates[k][rmcg_pkg::UNIT_CONV] = hwdata[rmcg_pkg::CONV_BIT];
							s_d.gates[k][rmcg_pkg::UNIT_WDT] = hwdata[rmcg_pkg::WDT_BIT];
							s_d.rate[k] = hwdata[rmcg_pkg::RATE_LSB +: 2];
						end
					end
				end
				rmcg_pkg::RUN_CFG_OFS: begin
					s_d.auto_gate = hwdata[rmcg_pkg::AUTO_GATE_BIT];
				end
				rmcg_pkg::IRQ_STAT_OFS: begin
					// Write one to clear; the event merge below keeps new events.
					s_d.stat = s_q.stat & ~hwdata[2:0];
				end
				rmcg_pkg::IRQ_MASK_OFS: begin
					s_d.mask = hwdata[2:0];
				end
				default: begin
					// Unmapped offsets ignore writes.
				end
			endcase
		end
		// A fault in the clearing cycle survives, since setting wins.
		s_d.stat = s_d.stat | fault_ev;
		s_d.irq = |(s_d.stat & s_d.mask);
		// Capture the address phase; only whole-word writes are honoured.
		s_d.dp_valid = addr_ok;
		s_d.dp_write = addr_ok && hwrite && (hsize == rmcg_pkg::HSIZE_WORD);
		s_d.dp_addr = addr_ok ? haddr[11:0] : s_q.dp_addr;
		// Read data comes from next state so a read right after a write sees it.
		s_d.rdata = 32'h0000_0000;
		if (addr_ok && !hwrite) begin
			case (haddr[11:0])
				rmcg_pkg::RUN_GATE_OFS: begin
					s_d.rdata = gate_word(s_d.gates[0], s_d.rate[0]);
				end
				rmcg_pkg::SLEEP_GATE_OFS: begin
					s_d.rdata = gate_word(s_d.gates[1], s_d.rate[1]);
				end
				rmcg_pkg::DEEP_GATE_OFS: begin
					s_d.rdata = gate_word(s_d.gates[2], s_d.rate[2]);
				end
				rmcg_pkg::RUN_CFG_OFS: begin
					s_d.rdata[rmcg_pkg::AUTO_GATE_BIT] = s_d.auto_gate;
				end
				rmcg_pkg::IRQ_STAT_OFS: begin
					s_d.rdata[2:0] = s_d.stat;
				end
				rmcg_pkg::IRQ_MASK_OFS: begin
					s_d.rdata[2:0] = s_d.mask;
				end
				default: begin
					// Unmapped offsets read as zero.
					s_d.rdata = 32'h0000_0000;
				end
			endcase
		end
		// The sample rate follows the same set choice as the unit enables.
		s_d.rate_out = s_q.rate[set_idx];
	end

	// Set in force: the run set unless auto gating is on in a sleep state.
	always_comb begin
		set_idx = 2'h0;
		if (s_q.auto_gate) begin
			case (pmode)
				rmcg_pkg::PM_SLEEP: begin
					set_idx = 2'h1;
				end
				rmcg_pkg::PM_DEEP: begin
					set_idx = 2'h2;
				end
				default: begin
					set_idx = 2'h0;
				end
			endcase
		end
	end

	// State register.
	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int k = 0; k < rmcg_pkg::NUM_SETS; k++) begin
				s_q.gates[k] <= rmcg_pkg::UNITS_RESET;
				s_q.rate[k] <= rmcg_pkg::RATE_RESET;
			end
			s_q.auto_gate <= 1'b0;
			s_q.stat <= rmcg_pkg::STAT_RESET;
			s_q.mask <= rmcg_pkg::MASK_RESET;
			s_q.dp_valid <= 1'b0;
			s_q.dp_write <= 1'b0;
			s_q.dp_addr <= 12'h000;
			s_q.rdata <= 32'h0000_0000;
			s_q.readyout <= 1'b1;
			s_q.resp <= rmcg_pkg::HRESP_OKAY;
			s_q.irq <= 1'b0;
			s_q.rate_out <= rmcg_pkg::RATE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// One gate stage per unit; each registers its own enable once more, so a
	// write reaches the unit clock one edge after its data phase ends.
	for (genvar u = 0; u < rmcg_pkg::NUM_UNITS; u++) begin : g_unit
		rmcg_gate_sel u_gate (
			.mclk        (mclk),
			.reset       (reset),
			.run_en      (s_q.gates[0][u]),
			.sleep_en    (s_q.gates[1][u]),
			.deep_en     (s_q.gates[2][u]),
			.auto_gate   (s_q.auto_gate),
			.pmode       (pmode),
			.unit_access (unit_access[u]),
			.unit_clk_en (unit_clk_en[u]),
			.unit_fault  (fault_ev[u])
		);
	end

	// Outputs straight from registers.
	assign hreadyout             = s_q.readyout;
	assign hresp                 = s_q.resp;
	assign hrdata                = s_q.rdata;
	assign unit_fault            = fault_ev;
	assign converter_sample_rate = s_q.rate_out;
	assign irq                   = s_q.irq;

endmodule

// *** verification/rmcg_props.sv ***
`timescale 1ns/100ps
// Watches the ports of the gating block; everything runs on one clock.
module rmcg_props (
	// Clock and reset.
	input wire logic        mclk,
	input wire logic        reset,
	// Bus.
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// Power state and units.
	input wire logic        sleep_mode,
	input wire logic        deep_sleep_mode,
	input wire logic [2:0]  unit_access,
	input wire logic [2:0]  unit_clk_en,
	input wire logic [2:0]  unit_fault,
	input wire logic [1:0]  converter_sample_rate,
	input wire logic        irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	logic take; // Address phase taken.
	logic slp;  // Any low-power state.
	logic wr;   // Taken write.
	assign take = hsel && htrans[1] && hready;
	assign slp = sleep_mode || deep_sleep_mode;
	assign wr = take && hwrite;
	a_fault_pulse: assert property (!$past(reset) |-> unit_fault == $past(unit_access & ~unit_clk_en))
		else $error("fault pulse wrong");
	a_on_no_fault: assert property ((unit_fault & $past(unit_clk_en)) == 3'h0)
		else $error("fault on clocked unit");
	a_run_write: assert property ((wr && hsize == rmcg_pkg::HSIZE_WORD && haddr[11:0] ==
		rmcg_pkg::RUN_GATE_OFS && !slp ##1 !slp [*3]) |-> unit_clk_en == {$past(hwdata[3], 2),
		$past(hwdata[16], 2), $past(hwdata[20], 2)} && converter_sample_rate == $past(hwdata[9:8], 2))
		else $error("run write not applied");
	a_rsv_read: assert property (take && !hwrite && haddr[11:0] == rmcg_pkg::RUN_GATE_OFS |=>
		(hrdata & 32'hffee_fcf7) == rmcg_pkg::GATE_RESET)
		else $error("reserved bits wrong");
	a_gate_steady: assert property (!$past(reset) && !$stable({unit_clk_en, converter_sample_rate})
		|-> $past(wr, 2) || $past(wr, 3) || slp || $past(slp) || $past(slp, 2))
		else $error("enable moved without cause");
	a_reset_quiet: assert property ($past(reset) |-> unit_clk_en == 3'h0 && unit_fault == 3'h0 &&
		converter_sample_rate == 2'h0 && !irq)
		else $error("outputs not quiet after reset");
	a_bus_okay: assert property (hreadyout && hresp == rmcg_pkg::HRESP_OKAY)
		else $error("bus stall or error");
	// A mask write lands at the end of its data phase, and irq follows at that same edge.
	a_irq_cause: assert property ($rose(irq) |-> $past(unit_fault != 3'h0) || $past(wr) || $past(wr, 2))
		else $error("interrupt without cause");
endmodule
bind rmcg_top rmcg_props u_props (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sleep_mode(sleep_mode),
	.deep_sleep_mode(deep_sleep_mode), .unit_access(unit_access), .unit_clk_en(unit_clk_en),
	.unit_fault(unit_fault), .converter_sample_rate(converter_sample_rate), .irq(irq));

// *** verification/rmcg_top_tb_top.sv ***
`timescale 1ns/100ps
// Drives the gating block over its bus and unit pins and compares with the register map.
module rmcg_top_tb_top;
	logic        mclk = 1'b0;
	logic        reset = 1'b1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic        sleep_mode = 1'b0;
	logic        deep_sleep_mode = 1'b0;
	logic [2:0]  unit_access = 3'h0;
	logic        hreadyout, hresp, irq;
	logic [31:0] hrdata, rd;
	logic [2:0]  unit_clk_en, unit_fault;
	logic [1:0]  converter_sample_rate;
	int          num_errors = 0;
	int          n_compared = 0;
	// Enable bit of each unit, in the order of the enable outputs.
	logic [31:0] unit_bit [3] = '{32'h0010_0000, 32'h0001_0000, 32'h0000_0008};
	logic [1:0]  rates [3] = '{rmcg_pkg::RATE_125K, rmcg_pkg::RATE_250K, rmcg_pkg::RATE_500K};
	always #5 mclk = ~mclk;
	// The slave's ready is fed back as the bus ready, as with a lone slave.
	rmcg_top uut (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sleep_mode(sleep_mode),
		.deep_sleep_mode(deep_sleep_mode), .unit_access(unit_access), .unit_clk_en(unit_clk_en),
		.unit_fault(unit_fault), .converter_sample_rate(converter_sample_rate), .irq(irq));
	// Compares one value; unknown bits never match.
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Waits for ready at a rising edge, bounded so a stuck slave cannot hang us.
	task wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) num_errors++;
	endtask
	// One single word transfer; read data lands in rd.
	task bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= w;
		hsize <= rmcg_pkg::HSIZE_WORD;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	// Reads a register and compares it.
	task rd_chk(input logic [11:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		check(rd, exp);
	endtask
	// Lets levels settle past the edge updates.
	task idle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task finish_test();
		$display("errors %0d compares %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Main sequence.
	initial begin
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		rd_chk(rmcg_pkg::RUN_GATE_OFS, rmcg_pkg::GATE_RESET);
		rd_chk(rmcg_pkg::SLEEP_GATE_OFS, rmcg_pkg::GATE_RESET);
		rd_chk(rmcg_pkg::DEEP_GATE_OFS, rmcg_pkg::GATE_RESET);
		rd_chk(12'h200, 32'h0);
		check(unit_clk_en, 3'h0);
		// All ones reach only the writable fields.
		bus(rmcg_pkg::RUN_GATE_OFS, 1'b1, 32'hffff_ffff);
		rd_chk(rmcg_pkg::RUN_GATE_OFS, 32'h0011_0348);
		idle(2);
		check(unit_clk_en, 3'h7);
		// Each unit alone, with each rate encoding; no rate above the documented top.
		for (int i = 0; i < 3; i++) begin
			bus(rmcg_pkg::RUN_GATE_OFS, 1'b1, unit_bit[i] | {22'h0, rates[i], 8'h0});
			idle(3);
			check(unit_clk_en, 3'h1 << i);
			check(converter_sample_rate, rates[i]);
		end
		// Only the watchdog is clocked now, so the other two fault.
		@(posedge mclk);
		unit_access <= 3'h7;
		@(posedge mclk);
		unit_access <= 3'h0;
		#1;
		check(unit_fault, 3'h3);
		idle(2);
		check(irq, 1'b0);
		bus(rmcg_pkg::IRQ_MASK_OFS, 1'b1, 32'h2);
		idle(2);
		check(irq, 1'b1);
		rd_chk(rmcg_pkg::IRQ_STAT_OFS, 32'h3);
		bus(rmcg_pkg::IRQ_STAT_OFS, 1'b1, 32'h3);
		idle(2);
		check(irq, 1'b0);
		// Sleep swaps the set only once auto gating is selected.
		bus(rmcg_pkg::SLEEP_GATE_OFS, 1'b1, 32'h0001_0000);
		sleep_mode <= 1'b1;
		idle(4);
		check(unit_clk_en, 3'h4);
		bus(rmcg_pkg::RUN_CFG_OFS, 1'b1, 32'h1);
		idle(4);
		check(unit_clk_en, 3'h2);
		@(posedge mclk);
		deep_sleep_mode <= 1'b1;
		idle(4);
		check(unit_clk_en, 3'h0);
		@(posedge mclk);
		sleep_mode <= 1'b0;
		deep_sleep_mode <= 1'b0;
		idle(4);
		check(unit_clk_en, 3'h4);
		check(converter_sample_rate, rmcg_pkg::RATE_500K);
		// A second reset in mid-run.
		@(posedge mclk);
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		rd_chk(rmcg_pkg::RUN_GATE_OFS, rmcg_pkg::GATE_RESET);
		check(unit_clk_en, 3'h0);
		finish_test();
	end
	// Cuts a hang short; the whole run needs far less.
	initial begin
		#100000;
		num_errors++;
		finish_test();
	end
endmodule
